// ===== hw/bpd_mb_vec.sv
// b-picture macroblock syntax interpreter and vector deriver
// assumes: one 100 MHz clock, parser supplies neighbour predictors
`include "bpd_params.svh"
// --------------------------------------------------------------
// top module
// --------------------------------------------------------------
module bpd_mb_vec
  import bpd_pkg::*;
(
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst,
  input  wire logic [7:0]             i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [31:0]            o_rdata,
  input  wire logic                   i_ref_push,
  input  wire logic [`BPD_PIC_W-1:0]  i_ref_pic_id,
  input  wire logic                   i_mb_valid,
  input  wire logic [4:0]             i_macroblock_kind,
  input  wire logic [15:0]            i_sub_codes,
  input  wire logic [4:0]             i_col_blocks,
  output logic                        o_mb_ready,
  output logic                        o_hdr_valid,
  output logic                        o_need_intra_dir,
  output logic [3:0]                  o_need_ref_idx,
  output logic [3:0]                  o_need_fwd_delta,
  output logic [3:0]                  o_need_bwd_delta,
  input  wire logic                   i_vec_valid,
  output logic                        o_vec_ready,
  input  wire bpd_mv_t                i_forward_vector_delta_x,
  input  wire bpd_mv_t                i_forward_vector_delta_y,
  input  wire bpd_mv_t                i_backward_vector_delta_x,
  input  wire bpd_mv_t                i_backward_vector_delta_y,
  input  wire bpd_mv_t                i_fwd_pred_x,
  input  wire bpd_mv_t                i_fwd_pred_y,
  input  wire logic                   i_fwd_pred_ok,
  input  wire bpd_mv_t                i_bwd_pred_x,
  input  wire bpd_mv_t                i_bwd_pred_y,
  input  wire logic                   i_bwd_pred_ok,
  input  wire logic [1:0]             i_ref_idx,
  input  wire bpd_mv_t                i_col_mv_x,
  input  wire bpd_mv_t                i_col_mv_y,
  input  wire logic [1:0]             i_col_ref,
  input  wire logic                   i_col_intra,
  input  wire logic                   i_col_same_frame,
  output logic                        o_vec_valid,
  output logic                        o_use_fwd,
  output logic                        o_use_bwd,
  output bpd_mv_t                     o_fwd_mv_x,
  output bpd_mv_t                     o_fwd_mv_y,
  output bpd_mv_t                     o_bwd_mv_x,
  output bpd_mv_t                     o_bwd_mv_y,
  output logic [`BPD_PIC_W-1:0]       o_fwd_ref_pic,
  output bpd_bref_e                   o_bwd_ref_sel,
  output logic                        o_mc_req
);

  // ------------------------------------------------------------
  // decode functions
  // ------------------------------------------------------------
  function automatic logic [1:0] sub_dir(input logic [3:0] s);
    logic [1:0] d;
    d = 2'h0;
    if (s >= 4'h1 && s <= `BPD_S_8X8_END)
      d = s[1:0];
    else if (s > `BPD_S_8X8_END && s <= `BPD_S_HALF_END)
      d = (s < 4'h6) ? `BPD_D_F :
          (s < 4'h8) ? `BPD_D_B : `BPD_D_BI;
    else if (s > `BPD_S_HALF_END && s <= `BPD_S_4X4_END)
      d = 2'(s - 4'h9);
    return d;
  endfunction

  function automatic logic [4:0] sub_count(input logic [3:0] s);
    logic [4:0] n;
    n = 5'h00;
    if (s == `BPD_S_DIRECT || s > `BPD_S_HALF_END)
      n = 5'h04;
    else if (s > `BPD_S_8X8_END)
      n = 5'h02;
    else
      n = 5'h01;
    if (s >= `BPD_S_INTRA)
      n = 5'h00;
    return n;
  endfunction

  // direction of one half of a 16x8 / 8x16 kind
  function automatic logic [1:0] pair_dir(input logic [4:0] k,
                                          input logic       second);
    logic [3:0] p;
    logic [1:0] d;
    p = 4'((k - `BPD_K_PAIR0) >> 1);
    d = `BPD_D_BI;
    case (p)
      4'h0: d = `BPD_D_F;
      4'h1: d = `BPD_D_B;
      4'h2: d = second ? `BPD_D_B : `BPD_D_F;
      4'h3: d = second ? `BPD_D_F : `BPD_D_B;
      4'h4: d = second ? `BPD_D_BI : `BPD_D_F;
      4'h5: d = second ? `BPD_D_BI : `BPD_D_B;
      4'h6: d = second ? `BPD_D_F : `BPD_D_BI;
      4'h7: d = second ? `BPD_D_B : `BPD_D_BI;
      default: d = `BPD_D_BI;
    endcase
    return d;
  endfunction

  // signed scale, truncating toward zero per component
  function automatic bpd_mv_t scale(input bpd_mv_t            mv,
                                    input logic signed [9:0]  num,
                                    input logic [`BPD_TR_W-1:0] den);
    logic signed [21:0] prod;
    logic signed [21:0] quo;
    prod = 22'(num * mv);
    quo  = 22'sh0;
    if (den != '0)
      quo = prod / $signed({14'h0, den});
    return bpd_mv_t'(quo);
  endfunction

  function automatic logic is_pair(input logic [4:0] k);
    return k >= `BPD_K_PAIR0 && k <= `BPD_K_PAIR1;
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  bpd_state_s s_q;
  bpd_state_s s_d;

  always_comb
  begin
    logic [1:0]        dir;
    logic              direct;
    logic              acc;
    logic              same;
    logic [3:0]        subq;
    logic signed [9:0] nf;
    logic signed [9:0] nb;
    bpd_mv_t           fx;
    bpd_mv_t           fy;
    bpd_mv_t           bx;
    bpd_mv_t           by;
    logic [1:0]        hd;
    dir    = 2'h0;
    hd     = 2'h0;
    acc    = 1'b0;
    direct = 1'b0;
    same   = 1'b0;
    subq   = s_q.sub[s_q.quad];
    nf     = $signed({2'h0, s_q.trb});
    nb     = 10'(nf - $signed({2'h0, s_q.trd}));
    fx     = '0;
    fy     = '0;
    bx     = '0;
    by     = '0;
    s_d    = s_q;
    s_d.hdr_valid = 1'b0;
    s_d.vec_valid = 1'b0;
    s_d.mc_req    = 1'b0;
    s_d.rdata     = 32'h0000_0000;

    // register bus
    if (i_wr && i_addr == `BPD_A_CTRL)
    begin
      s_d.multi  = i_wdata[`BPD_F_MULTI];
      s_d.field  = i_wdata[`BPD_F_FIELD];
      s_d.field2 = i_wdata[`BPD_F_FIELD2];
    end
    if (i_wr && i_addr == `BPD_A_TEMP)
    begin
      s_d.trb = i_wdata[`BPD_TR_W-1:0];
      s_d.trd = i_wdata[`BPD_F_TRD_HI:`BPD_F_TRD_LO];
    end
    if (i_rd)
      case (i_addr)
        `BPD_A_CTRL: s_d.rdata = {29'h0, s_q.field2, s_q.field,
                                  s_q.multi};
        `BPD_A_TEMP: s_d.rdata = {16'h0, s_q.trd, s_q.trb};
        `BPD_A_STAT: s_d.rdata = {s_q.vcnt, 14'h0, s_q.st};
        `BPD_A_REFS: s_d.rdata = s_q.refs;
        default:     s_d.rdata = 32'h0000_0000;
      endcase

    // reference buffer, newest always at slot 0
    if (i_ref_push)
      s_d.refs = {s_q.refs[`BPD_REF_DEPTH-2:0], i_ref_pic_id};

    // direction and kind of the part being served
    if (s_q.kind == `BPD_K_SPLIT)
    begin
      dir    = sub_dir(subq);
      direct = subq == `BPD_S_DIRECT;
    end
    else if (s_q.kind == `BPD_K_DIRECT)
      direct = 1'b1;
    else if (is_pair(s_q.kind))
      dir = pair_dir(s_q.kind, s_q.left == 5'h01);
    else
      dir = s_q.kind[1:0];

    // direct scaling: field 2 onto field 1 of its own frame negates trb forward and uses -(trb + trd) backward
    same = s_q.field && s_q.field2 && i_col_same_frame;
    if (same)
    begin
      nf = 10'(-nf);
      nb = 10'(-($signed({2'h0, s_q.trb}) +
                 $signed({2'h0, s_q.trd})));
    end

    acc = s_q.vec_ready && i_vec_valid;
    case (s_q.st)
      BPD_IDLE:
        if (s_q.mb_ready && i_mb_valid)
        begin
          s_d.kind       = i_macroblock_kind;
          s_d.sub        = i_sub_codes;
          s_d.hdr_valid  = 1'b1;
          s_d.need_ref   = 4'h0;
          s_d.need_fwd   = 4'h0;
          s_d.need_bwd   = 4'h0;
          s_d.need_intra = i_macroblock_kind == `BPD_K_I4;
          s_d.quad       = 2'h3;
          s_d.left       = 5'h01;
          s_d.st         = BPD_VEC;
          if (i_macroblock_kind == `BPD_K_DIRECT)
            s_d.left = i_col_blocks;
          else if (is_pair(i_macroblock_kind))
          begin
            s_d.left = 5'h02;
            for (int h = 0; h < 2; h++)
            begin
              hd              = pair_dir(i_macroblock_kind, h[0]);
              s_d.need_fwd[h] = hd[0];
              s_d.need_bwd[h] = hd[1];
            end
          end
          else if (i_macroblock_kind == `BPD_K_SPLIT)
          begin
            s_d.quad = 2'h0;
            s_d.left = sub_count(i_sub_codes[3:0]);
            for (int q = 0; q < 4; q++)
            begin
              hd              = sub_dir(i_sub_codes[q*4 +: 4]);
              s_d.need_fwd[q] = hd[0];
              s_d.need_bwd[q] = hd[1];
              if (i_sub_codes[q*4 +: 4] == `BPD_S_INTRA)
                s_d.need_intra = 1'b1;
            end
          end
          else if (i_macroblock_kind <= `BPD_K_BI16)
          begin
            s_d.need_fwd[0] = i_macroblock_kind[0];
            s_d.need_bwd[0] = i_macroblock_kind[1];
          end
          else
            s_d.st = BPD_IDLE;
          if (s_q.multi)
            s_d.need_ref = s_d.need_fwd;
        end
      BPD_VEC:
        if (s_q.left == 5'h00)
        begin
          // quadrant exhausted or intra: move on without a vector
          if (s_q.quad == 2'h3)
            s_d.st = BPD_REQ;
          else
          begin
            s_d.quad = 2'(s_q.quad + 2'h1);
            s_d.left = sub_count(s_q.sub[2'(s_q.quad + 2'h1)]);
          end
        end
        else if (acc)
        begin
          s_d.left      = 5'(s_q.left - 5'h01);
          s_d.vec_valid = 1'b1;
          s_d.vcnt      = 16'(s_q.vcnt + 16'h0001);
          if (direct)
          begin
            if (!i_col_intra)
            begin
              fx = scale(i_col_mv_x, nf, s_q.trd);
              fy = scale(i_col_mv_y, nf, s_q.trd);
              bx = scale(i_col_mv_x, nb, s_q.trd);
              by = scale(i_col_mv_y, nb, s_q.trd);
            end
            s_d.use_fwd = !same;
            s_d.use_bwd = 1'b1;
            s_d.fref = s_q.multi ? s_q.refs[i_col_ref]
                                 : s_q.refs[0];
            s_d.bref = same ? BPD_BR_BOTH_FIELDS :
                       !s_q.field ? BPD_BR_NEXT_FRAME :
                       s_q.field2 ? BPD_BR_SAME_PARITY :
                       BPD_BR_FIELD1;
          end
          else
          begin
            // absent neighbour of this direction predicts zero
            fx = 12'(i_forward_vector_delta_x +
                 (i_fwd_pred_ok ? i_fwd_pred_x : '0));
            fy = 12'(i_forward_vector_delta_y +
                 (i_fwd_pred_ok ? i_fwd_pred_y : '0));
            bx = 12'(i_backward_vector_delta_x +
                 (i_bwd_pred_ok ? i_bwd_pred_x : '0));
            by = 12'(i_backward_vector_delta_y +
                 (i_bwd_pred_ok ? i_bwd_pred_y : '0));
            if (!dir[0])
            begin
              fx = '0;
              fy = '0;
            end
            if (!dir[1])
            begin
              bx = '0;
              by = '0;
            end
            s_d.use_fwd = dir[0];
            s_d.use_bwd = dir[1];
            // code n names the picture n+1 back, slot n
            s_d.fref = s_q.multi ? s_q.refs[i_ref_idx]
                                 : s_q.refs[0];
            s_d.bref = s_q.field ? BPD_BR_SAME_PARITY
                                 : BPD_BR_NEXT_FRAME;
          end
          s_d.fmx = fx;
          s_d.fmy = fy;
          s_d.bmx = bx;
          s_d.bmy = by;
        end
      BPD_REQ:
      begin
        s_d.mc_req = 1'b1;
        s_d.st     = BPD_IDLE;
      end
      default: s_d.st = BPD_IDLE;
    endcase
    s_d.mb_ready  = s_d.st == BPD_IDLE;
    s_d.vec_ready = s_d.st == BPD_VEC && s_d.left != 5'h00;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_q          <= '0;
      s_q.st       <= BPD_IDLE;
      s_q.mb_ready <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign o_rdata          = s_q.rdata;
  assign o_mb_ready       = s_q.mb_ready;
  assign o_hdr_valid      = s_q.hdr_valid;
  assign o_need_intra_dir = s_q.need_intra;
  assign o_need_ref_idx   = s_q.need_ref;
  assign o_need_fwd_delta = s_q.need_fwd;
  assign o_need_bwd_delta = s_q.need_bwd;
  assign o_vec_ready      = s_q.vec_ready;
  assign o_vec_valid      = s_q.vec_valid;
  assign o_use_fwd        = s_q.use_fwd;
  assign o_use_bwd        = s_q.use_bwd;
  assign o_fwd_mv_x       = s_q.fmx;
  assign o_fwd_mv_y       = s_q.fmy;
  assign o_bwd_mv_x       = s_q.bmx;
  assign o_bwd_mv_y       = s_q.bmy;
  assign o_fwd_ref_pic    = s_q.fref;
  assign o_bwd_ref_sel    = s_q.bref;
  assign o_mc_req         = s_q.mc_req;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  logic acc_w;
  assign acc_w = s_q.vec_ready && i_vec_valid;

  sequence s_hdr_take;
    s_q.mb_ready && i_mb_valid;
  endsequence
  sequence s_last_vec;
    acc_w && s_q.left == 5'h01 && s_q.quad == 2'h3;
  endsequence

  property p_direct_no_delta;
    s_hdr_take and i_macroblock_kind == `BPD_K_DIRECT
      |=> o_hdr_valid && o_need_fwd_delta == 4'h0
          && o_need_bwd_delta == 4'h0;
  endproperty
  a_direct_no_delta: assert property (p_direct_no_delta)
    else $error("direct kind asked for vector deltas");

  property p_intra_none;
    s_hdr_take and i_macroblock_kind >= `BPD_K_I4
      |=> o_need_fwd_delta == 4'h0 ##1 o_mb_ready && !o_vec_ready;
  endproperty
  a_intra_none: assert property (p_intra_none)
    else $error("intra macroblock entered vector parsing");

  property p_intra_dir;
    s_hdr_take and i_macroblock_kind == `BPD_K_I4
      |=> o_need_intra_dir;
  endproperty
  a_intra_dir: assert property (p_intra_dir)
    else $error("intra direction code not requested");

  property p_single_ref;
    o_hdr_valid && !s_q.multi |-> o_need_ref_idx == 4'h0;
  endproperty
  a_single_ref: assert property (p_single_ref)
    else $error("reference index requested without multi ref");

  property p_fifo;
    i_ref_push |=> s_q.refs[0] == $past(i_ref_pic_id)
      && s_q.refs[1] == $past(s_q.refs[0]);
  endproperty
  a_fifo: assert property (p_fifo)
    else $error("reference buffer not first in first out");

  property p_zero_pred;
    acc_w && s_q.kind == `BPD_K_F16 && !i_fwd_pred_ok
      |=> o_vec_valid && o_fwd_mv_x == $past(i_forward_vector_delta_x);
  endproperty
  a_zero_pred: assert property (p_zero_pred)
    else $error("absent predictor was not taken as zero");

  property p_col_intra;
    acc_w && s_q.kind == `BPD_K_DIRECT && i_col_intra
      |=> o_fwd_mv_x == '0 && o_fwd_mv_y == '0
          && o_bwd_mv_x == '0 && o_bwd_mv_y == '0;
  endproperty
  a_col_intra: assert property (p_col_intra)
    else $error("direct vectors not zero for intra co-located");

  property p_req_after_last;
    s_last_vec |=> o_vec_valid && !o_mc_req ##1 !o_mc_req ##1 o_mc_req;
  endproperty
  a_req_after_last: assert property (p_req_after_last)
    else $error("request not two cycles after last vector");

  property p_frame_bref;
    acc_w && !s_q.field |=> o_bwd_ref_sel == BPD_BR_NEXT_FRAME;
  endproperty
  a_frame_bref: assert property (p_frame_bref)
    else $error("frame picture backward ref not next frame");

endmodule // bpd_mb_vec

// ===== hw/bpd_params.svh
// constants for the b-picture vector deriver
// assumes: included by bpd_pkg and the top module
`ifndef BPD_PARAMS_SVH
`define BPD_PARAMS_SVH
// --------------------------------------------------------------
// widths
// --------------------------------------------------------------
`define BPD_MV_W      12
`define BPD_TR_W      8
`define BPD_PIC_W     8
`define BPD_REF_DEPTH 4
// --------------------------------------------------------------
// macroblock kind codes
// --------------------------------------------------------------
`define BPD_K_DIRECT  5'h00
`define BPD_K_F16     5'h01
`define BPD_K_B16     5'h02
`define BPD_K_BI16    5'h03
`define BPD_K_PAIR0   5'h04
`define BPD_K_PAIR1   5'h15
`define BPD_K_SPLIT   5'h16
`define BPD_K_I4      5'h17
`define BPD_K_I16     5'h18
// --------------------------------------------------------------
// sub-partition codes
// --------------------------------------------------------------
`define BPD_S_DIRECT  4'h0
`define BPD_S_8X8_END 4'h3
`define BPD_S_HALF_END 4'h9
`define BPD_S_4X4_END 4'hc
`define BPD_S_INTRA   4'hd
// --------------------------------------------------------------
// direction codes {bwd, fwd}
// --------------------------------------------------------------
`define BPD_D_F       2'h1
`define BPD_D_B       2'h2
`define BPD_D_BI      2'h3
// --------------------------------------------------------------
// register map and fields
// --------------------------------------------------------------
`define BPD_A_CTRL    8'h00
`define BPD_A_TEMP    8'h04
`define BPD_A_STAT    8'h08
`define BPD_A_REFS    8'h0c
`define BPD_F_MULTI   0
`define BPD_F_FIELD   1
`define BPD_F_FIELD2  2
`define BPD_F_TRD_LO  8
`define BPD_F_TRD_HI  15
`define BPD_F_CNT_LO  16
`endif

// ===== hw/bpd_pkg.sv
// types for the b-picture vector deriver
// assumes: bpd_params.svh is on the include path
`include "bpd_params.svh"
package bpd_pkg;
  typedef enum logic [1:0] {BPD_IDLE, BPD_VEC, BPD_REQ} bpd_state_e;
  // backward reference selection toward motion compensation
  typedef enum logic [1:0] {
    BPD_BR_NEXT_FRAME,
    BPD_BR_SAME_PARITY,
    BPD_BR_FIELD1,
    BPD_BR_BOTH_FIELDS
  } bpd_bref_e;
  typedef logic signed [`BPD_MV_W-1:0] bpd_mv_t;
  typedef struct packed {
    bpd_state_e                            st;
    logic [4:0]                            kind;
    logic [3:0][3:0]                       sub;
    logic [1:0]                            quad;
    logic [4:0]                            left;
    logic [`BPD_REF_DEPTH-1:0][`BPD_PIC_W-1:0] refs;
    logic                                  multi;
    logic                                  field;
    logic                                  field2;
    logic [`BPD_TR_W-1:0]                  trb;
    logic [`BPD_TR_W-1:0]                  trd;
    logic [15:0]                           vcnt;
    logic                                  mb_ready;
    logic                                  vec_ready;
    logic                                  hdr_valid;
    logic                                  need_intra;
    logic [3:0]                            need_ref;
    logic [3:0]                            need_fwd;
    logic [3:0]                            need_bwd;
    logic                                  vec_valid;
    logic                                  use_fwd;
    logic                                  use_bwd;
    bpd_mv_t                               fmx;
    bpd_mv_t                               fmy;
    bpd_mv_t                               bmx;
    bpd_mv_t                               bmy;
    logic [`BPD_PIC_W-1:0]                 fref;
    bpd_bref_e                             bref;
    logic                                  mc_req;
    logic [31:0]                           rdata;
  } bpd_state_s;
endpackage

// ===== verification/bpd_pmodel.sv
// parser stand-in offering vector blocks
// assumes: design takes a block while its ready is high
module bpd_pmodel (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_en,
  output logic      o_vld
);
  timeunit 1ns;
  timeprecision 1ps;
  // held high: only the design's ready paces the blocks
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      o_vld <= 1'b0;
    else
      o_vld <= i_en;
endmodule // bpd_pmodel

// ===== verification/tb.sv
// self-checking bench for bpd_mb_vec
// assumes: bpd_pkg and bpd_pmodel compiled first
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bpd_pkg::*;
  typedef struct packed
  {logic [4:0] k; logic [15:0] s; logic [8:0] n;} bpd_row_s;
  logic i_sys_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_mb_valid = 0;
  logic i_ref_push = 0, ok = 0, i_col_intra = 0, i_col_same_frame = 0;
  logic en = 0, vld;
  logic [7:0] i_addr = 0, i_ref_pic_id = 0;
  logic [31:0] i_wdata = 0, o_rdata;
  logic [4:0] i_macroblock_kind = 0, i_col_blocks = 1;
  logic [15:0] i_sub_codes = 0;
  logic [1:0] i_ref_idx = 1, i_col_ref = 1;
  bpd_mv_t dv = 12'sh005, pv = 12'sh003, cx = -12'sh007;
  logic o_mb_ready, o_hdr_valid, o_need_intra_dir, o_vec_ready;
  logic o_vec_valid, o_use_fwd, o_use_bwd, o_mc_req;
  logic [3:0] o_need_ref_idx, o_need_fwd_delta, o_need_bwd_delta;
  bpd_mv_t o_fwd_mv_x, o_fwd_mv_y, o_bwd_mv_x, o_bwd_mv_y;
  logic [7:0] o_fwd_ref_pic;
  bpd_bref_e o_bwd_ref_sel;
  int failures = 0, total_checks = 0;
  bpd_row_s rows[9] = '{'{5'h00, 16'h0000, 9'h000},
    '{5'h01, 16'h0000, 9'h020}, '{5'h02, 16'h0000, 9'h002},
    '{5'h03, 16'h0000, 9'h022}, '{5'h08, 16'h0000, 9'h024},
    '{5'h14, 16'h0000, 9'h066}, '{5'h16, 16'h0a2d, 9'h085},
    '{5'h17, 16'h0000, 9'h001}, '{5'h18, 16'h0000, 9'h000}};
  bpd_mb_vec DUT (.*, .i_vec_valid(vld), .i_fwd_pred_ok(ok),
    .i_bwd_pred_ok(ok), .i_col_mv_x(cx), .i_col_mv_y(cx),
    .i_forward_vector_delta_x(dv), .i_forward_vector_delta_y(dv),
    .i_backward_vector_delta_x(dv), .i_backward_vector_delta_y(dv),
    .i_fwd_pred_x(pv), .i_fwd_pred_y(pv), .i_bwd_pred_x(pv),
    .i_bwd_pred_y(pv));
  bpd_pmodel PM (.i_sys_clk, .i_rst, .i_en(en), .o_vld(vld));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(logic [31:0] g, logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  // bounded wait; running out counts as a mismatch
  task automatic upto(ref logic s);
    for (int i = 0; i < 200 && s !== 1'b1; i++)
      tick();
    chk(s, 1);
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 0;
    i_rd <= 0;
    #1 if (!w) chk(o_rdata, d);
  endtask
  task automatic mb(logic [4:0] k, logic [15:0] s);
    @(posedge i_sys_clk);
    i_macroblock_kind <= k;
    i_sub_codes <= s;
    i_mb_valid <= 1;
    @(posedge i_sys_clk);
    i_mb_valid <= 0;
    #1 chk(o_hdr_valid, 1);
    tick();
  endtask
  task automatic vt(logic [4:0] k, logic o, logic [1:0] ci,
                    logic [23:0] e, logic [12:0] r);
    @(posedge i_sys_clk);
    ok <= o;
    i_col_intra <= ci[0];
    i_col_same_frame <= ci[1];
    mb(k, 0);
    chk(o_need_ref_idx, {3'h0, r[12]});
    upto(o_vec_valid);
    chk(o_vec_ready, 0);
    chk({o_fwd_mv_x, o_bwd_mv_x}, e);
    chk({o_fwd_mv_y, o_bwd_mv_y}, e);
    chk({o_fwd_ref_pic, o_use_fwd, o_use_bwd, o_bwd_ref_sel},
        r[11:0]);
    tick(2);
    chk(o_mc_req, 1);
    upto(o_mb_ready);
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial
    forever #5 i_sys_clk = ~i_sys_clk;
  initial
  begin
    #60us;
    failures++;
    summarize();
  end
  initial
  begin
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 0;
    en <= 1;
    bus(1, 8'h00, 32'h0000_0001);
    for (int i = 1; i < 3; i++)
    begin
      @(posedge i_sys_clk);
      i_ref_push <= 1;
      i_ref_pic_id <= 8'(i * 17);
    end
    @(posedge i_sys_clk);
    i_ref_push <= 0;
    bus(0, 8'h0c, 32'h0000_1122);
    foreach (rows[i])
    begin
      mb(rows[i].k, rows[i].s);
      chk({o_need_fwd_delta, o_need_bwd_delta, o_need_intra_dir},
          rows[i].n);
      chk(o_need_ref_idx, rows[i].n[8:5]);
      upto(o_mb_ready);
    end
    bus(1, 8'h00, 32'h0000_0000);
    bus(1, 8'h04, 32'h0000_0302);
    bus(0, 8'h04, 32'h0000_0302);
    bus(0, 8'h44, 32'h0000_0000);
    vt(5'h01, 1, 0, 24'h008_000, 13'h0228);
    vt(5'h01, 0, 0, 24'h005_000, 13'h0228);
    vt(5'h02, 1, 0, 24'h000_008, 13'h0224);
    vt(5'h00, 0, 0, 24'hffc_002, 13'h022c);
    vt(5'h00, 0, 1, 24'h000_000, 13'h022c);
    bus(1, 8'h00, 32'h0000_0002);
    vt(5'h02, 1, 0, 24'h000_008, 13'h0225);
    vt(5'h00, 0, 0, 24'hffc_002, 13'h022e);
    bus(1, 8'h00, 32'h0000_0006);
    vt(5'h00, 0, 2, 24'h004_00b, 13'h0227);
    bus(1, 8'h00, 32'h0000_0001);
    vt(5'h01, 1, 0, 24'h008_000, 13'h1118);
    vt(5'h00, 0, 0, 24'hffc_002, 13'h011c);
    // mid-run reset: outputs back to idle, buffer emptied
    @(posedge i_sys_clk);
    i_rst <= 1;
    tick();
    chk({o_mb_ready, o_fwd_ref_pic, o_mc_req, o_need_ref_idx},
        32'h0000_2000);
    @(posedge i_sys_clk);
    i_rst <= 0;
    bus(0, 8'h0c, 32'h0000_0000);
    summarize();
  end
endmodule // tb
